// File: srs_cfg.svh
`ifndef SRS_CFG_SVH
`define SRS_CFG_SVH
// pressure word width, counts of 0.1 mTorr (1 count = 0.1 mTorr)
`define SRS_P_W 24
// factory thresholds in counts: 100 mTorr and 200 mTorr
`define SRS_ON_RST 24'h0003E8
`define SRS_OFF_RST 24'h0007D0
// station address nibble defaults
`define SRS_STN_LO_RST 4'h1
`define SRS_STN_HI_RST 4'h0
// span reading default, 760 Torr in counts
`define SRS_SPAN_RST 24'h73F780
// linear output limits default: 1 mTorr and 1 Torr
`define SRS_LIN_MIN_RST 24'h00000A
`define SRS_LIN_MAX_RST 24'h002710
// step applied by one key press
`define SRS_STEP 24'h000001
`endif

// File: srs_pkg.sv
package srs_pkg;
   typedef enum logic [1:0] {
      SRS_TORR = 2'b00,
      SRS_MBAR = 2'b01,
      SRS_PA = 2'b10
   } srs_unit_t;
   typedef enum logic [2:0] {
      SRS_SCR_MAIN = 3'b000,
      SRS_SCR_ZERO = 3'b001,
      SRS_SCR_UNIT = 3'b010,
      SRS_SCR_SPAN = 3'b011,
      SRS_SCR_SETPT = 3'b100,
      SRS_SCR_ADDR = 3'b101
   } srs_screen_t;
   typedef struct packed {
      logic store;
      logic next_page;
      logic step_up;
      logic step_down;
      logic zero_calibration;
      logic factory;
   } srs_keys_t;
   typedef struct packed {
      logic [23:0] on_thr;
      logic [23:0] off_thr;
   } srs_thr_t;
endpackage

// File: srs_relay.sv
`timescale 1ns/100ps
`include "srs_cfg.svh"
// one relay channel: thresholds, guarded edits and hysteresis
module srs_relay (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic resetn_i,
   // measurement and control
   input wire logic [`SRS_P_W-1:0] pressure_i,
   input wire logic disable_i,
   input wire logic restore_i,
   input wire logic on_edit_i,
   input wire logic off_edit_i,
   input wire logic up_i,
   input wire logic down_i,
   // outputs
   output srs_pkg::srs_thr_t thr_o,
   output logic relay_o
);
   import srs_pkg::*;
   logic [`SRS_P_W-1:0] on_q, off_q, on_try, off_try;
   logic relay_q;
   // candidate values; saturate at the ends of the range
   always_comb begin
      on_try = on_q;
      off_try = off_q;
      if (up_i && on_q != {`SRS_P_W{1'b1}}) on_try = on_q + `SRS_STEP;
      if (down_i && on_q != '0) on_try = on_q - `SRS_STEP;
      if (up_i && off_q != {`SRS_P_W{1'b1}}) off_try = off_q + `SRS_STEP;
      if (down_i && off_q != '0) off_try = off_q - `SRS_STEP;
   end
   // thresholds; an edit that would cross the other threshold is dropped
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         on_q <= `SRS_ON_RST;
         off_q <= `SRS_OFF_RST;
      end else if (restore_i) begin
         on_q <= `SRS_ON_RST;
         off_q <= `SRS_OFF_RST;
      end else begin
         if (on_edit_i && on_try < off_q) on_q <= on_try;
         if (off_edit_i && off_try > on_q) off_q <= off_try;
      end
   end
   // relay state with hysteresis band; disable forces release
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) relay_q <= 1'b0;
      else if (disable_i) relay_q <= 1'b0;
      else if (pressure_i < on_q) relay_q <= 1'b1;
      else if (pressure_i > off_q) relay_q <= 1'b0;
   end // between thresholds the state holds
   assign relay_o = relay_q;
   assign thr_o = '{on_thr: on_q, off_thr: off_q};

   a_on_below_off: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
      on_q < off_q) else $error("energize threshold not below release");
   a_edit_guard: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
      off_edit_i && !restore_i && !(off_try > on_q) |=> $stable(off_q))
      else $error("release threshold crossed energize");
   a_relay_energize: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
      !disable_i && pressure_i < on_q |=> relay_q) else $error("relay not energized");
   a_relay_release: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
      !disable_i && pressure_i > off_q && !(pressure_i < on_q) |=> !relay_q)
      else $error("relay not released");
   a_hold_band: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
      !disable_i && pressure_i >= on_q && pressure_i <= off_q |=> $stable(relay_q))
      else $error("relay moved inside band");
   a_relay_disable: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
      disable_i |=> !relay_q) else $error("relay active while disabled");
   a_restore_vals: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
      restore_i |=> on_q == `SRS_ON_RST && off_q == `SRS_OFF_RST)
      else $error("thresholds not restored");
   c_energize: cover property (@(posedge core_clk_i) disable iff (!resetn_i) $rose(relay_q));
   c_release: cover property (@(posedge core_clk_i) disable iff (!resetn_i) $fell(relay_q));
endmodule

// File: srs_top.sv
`timescale 1ns/100ps
`include "srs_cfg.svh"
// How it works
// - a relay energizes when pressure is below its energize threshold.
// - a relay releases when pressure is above its release threshold.
// - an energize threshold edit reaching the release threshold is refused.
// - a release threshold edit reaching the energize threshold is refused.
// - reset gives thresholds of 100 mTorr energize and 200 mTorr release.
// - a low relay-disable pin holds both relays released.
// - the address low nibble is the station-low setting, 0..15, default 1.
// - the address high nibble is the station-high setting, 0..15, default 0.
// - the combined address is matched for both serial ports.
// - the unit setting picks torr, millibar or pascal, default torr.
// - a unit change restores thresholds and linear limits to factory values.
// - zero calibration captures the present sensor reading.
// - in span calibration up/down adjust the reading and store commits it.
// - store commits and returns to main; next-page steps through screens.
module srs_top (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic resetn_i,
   // measurement and pins
   input wire logic [`SRS_P_W-1:0] pressure_i,
   input wire logic [`SRS_P_W-1:0] sensor_raw_i,
   input wire logic relay_disable_n_i,
   // front panel keys, one-cycle pulses
   input srs_pkg::srs_keys_t keys_i,
   // serial command address check
   input wire logic [7:0] cmd_addr_i,
   // relay outputs
   output logic relay_a_o,
   output logic relay_b_o,
   // settings and state
   output srs_pkg::srs_thr_t relay_a_thr_o,
   output srs_pkg::srs_thr_t relay_b_thr_o,
   output logic [7:0] station_addr_o,
   output logic addr_match_o,
   output srs_pkg::srs_unit_t unit_o,
   output srs_pkg::srs_screen_t screen_o,
   output logic [`SRS_P_W-1:0] zero_point_o,
   output logic [`SRS_P_W-1:0] span_value_o,
   output logic [`SRS_P_W-1:0] lin_min_o,
   output logic [`SRS_P_W-1:0] lin_max_o
);
   import srs_pkg::*;
   // ---------------------------------------------------------------
   // pin synchroniser
   // ---------------------------------------------------------------
   logic dis_meta_q, dis_q;
   // pin is asynchronous; first stage feeds only the second
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         dis_meta_q <= 1'b1;
         dis_q <= 1'b1;
      end else begin
         dis_meta_q <= ~relay_disable_n_i;
         dis_q <= dis_meta_q;
      end
   end
   // ---------------------------------------------------------------
   // screen navigation
   // ---------------------------------------------------------------
   srs_screen_t scr_q;
   logic sel_b_q, sel_off_q, sel_hi_q;
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         scr_q <= SRS_SCR_MAIN;
      end else if (keys_i.store) begin
         scr_q <= SRS_SCR_MAIN;
      end else if (keys_i.next_page) begin
         unique case (scr_q)
            SRS_SCR_MAIN: scr_q <= SRS_SCR_ZERO;
            SRS_SCR_ZERO: scr_q <= SRS_SCR_UNIT;
            SRS_SCR_UNIT: scr_q <= SRS_SCR_SPAN;
            SRS_SCR_SPAN: scr_q <= SRS_SCR_SETPT;
            SRS_SCR_SETPT: scr_q <= (sel_b_q && sel_off_q) ? SRS_SCR_ADDR : SRS_SCR_SETPT;
            SRS_SCR_ADDR: scr_q <= sel_hi_q ? SRS_SCR_MAIN : SRS_SCR_ADDR;
            default: scr_q <= SRS_SCR_MAIN;
         endcase
      end
   end
   // sub-page selectors walk a-on, a-off, b-on, b-off, then low, high nibble
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sel_b_q <= 1'b0;
         sel_off_q <= 1'b0;
         sel_hi_q <= 1'b0;
      end else if (keys_i.store || !keys_i.next_page) begin
         if (keys_i.store) begin
            sel_b_q <= 1'b0;
            sel_off_q <= 1'b0;
            sel_hi_q <= 1'b0;
         end
      end else if (scr_q == SRS_SCR_SETPT) begin
         sel_off_q <= ~sel_off_q;
         if (sel_off_q) sel_b_q <= ~sel_b_q;
      end else if (scr_q == SRS_SCR_ADDR) begin
         sel_hi_q <= ~sel_hi_q;
      end
   end
   // ---------------------------------------------------------------
   // units, calibration and linear limits
   // ---------------------------------------------------------------
   srs_unit_t unit_q;
   logic restore;
   logic [`SRS_P_W-1:0] zero_q, span_q, span_edit_q, lin_min_q, lin_max_q;
   // unit cycles on step keys; any change restores factory values
   assign restore = (scr_q == SRS_SCR_UNIT) && (keys_i.step_up || keys_i.step_down);
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         unit_q <= SRS_TORR;
      end else if (restore) begin
         unique case (unit_q)
            SRS_TORR: unit_q <= keys_i.step_up ? SRS_MBAR : SRS_PA;
            SRS_MBAR: unit_q <= keys_i.step_up ? SRS_PA : SRS_TORR;
            SRS_PA: unit_q <= keys_i.step_up ? SRS_TORR : SRS_MBAR;
            default: unit_q <= SRS_TORR;
         endcase
      end
   end
   // linear limits go back to factory torr values on unit change
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         lin_min_q <= `SRS_LIN_MIN_RST;
         lin_max_q <= `SRS_LIN_MAX_RST;
      end else if (restore) begin
         lin_min_q <= `SRS_LIN_MIN_RST;
         lin_max_q <= `SRS_LIN_MAX_RST;
      end
   end
   // zero point taken from raw sensor; operator must be below 1e-4 torr
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) zero_q <= '0;
      else if (keys_i.zero_calibration && scr_q == SRS_SCR_ZERO) zero_q <= sensor_raw_i;
   end
   // span edit copy is loaded on entry; only store commits it
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         span_q <= `SRS_SPAN_RST;
         span_edit_q <= `SRS_SPAN_RST;
      end else if (scr_q != SRS_SCR_SPAN) begin
         span_edit_q <= pressure_i;
      end else if (keys_i.store) begin
         span_q <= span_edit_q;
      end else if (keys_i.step_up) begin
         span_edit_q <= span_edit_q + `SRS_STEP;
      end else if (keys_i.step_down) begin
         span_edit_q <= span_edit_q - `SRS_STEP;
      end
   end
   // ---------------------------------------------------------------
   // station address
   // ---------------------------------------------------------------
   logic [3:0] stn_lo_q, station_high_nibble_q;
   logic addr_up, addr_dn;
   assign addr_up = (scr_q == SRS_SCR_ADDR) && keys_i.step_up;
   assign addr_dn = (scr_q == SRS_SCR_ADDR) && keys_i.step_down;
   // nibble counters wrap within 0..15
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         stn_lo_q <= `SRS_STN_LO_RST;
         station_high_nibble_q <= `SRS_STN_HI_RST;
      end else if (sel_hi_q) begin
         if (addr_up) station_high_nibble_q <= station_high_nibble_q + 4'h1;
         else if (addr_dn) station_high_nibble_q <= station_high_nibble_q - 4'h1;
      end else begin
         if (addr_up) stn_lo_q <= stn_lo_q + 4'h1;
         else if (addr_dn) stn_lo_q <= stn_lo_q - 4'h1;
      end
   end
   assign station_addr_o = {station_high_nibble_q, stn_lo_q};
   // one comparator serves both serial ports
   assign addr_match_o = (cmd_addr_i == station_addr_o);
   // ---------------------------------------------------------------
   // relay channels
   // ---------------------------------------------------------------
   logic edit_sp;
   assign edit_sp = (scr_q == SRS_SCR_SETPT);
   srs_relay u_relay_a (
      .core_clk_i(core_clk_i),
      .resetn_i(resetn_i),
      .pressure_i(pressure_i),
      .disable_i(dis_q),
      .restore_i(restore),
      .on_edit_i(edit_sp && !sel_b_q && !sel_off_q),
      .off_edit_i(edit_sp && !sel_b_q && sel_off_q),
      .up_i(keys_i.step_up),
      .down_i(keys_i.step_down),
      .thr_o(relay_a_thr_o),
      .relay_o(relay_a_o)
   );
   srs_relay u_relay_b (
      .core_clk_i(core_clk_i),
      .resetn_i(resetn_i),
      .pressure_i(pressure_i),
      .disable_i(dis_q),
      .restore_i(restore),
      .on_edit_i(edit_sp && sel_b_q && !sel_off_q),
      .off_edit_i(edit_sp && sel_b_q && sel_off_q),
      .up_i(keys_i.step_up),
      .down_i(keys_i.step_down),
      .thr_o(relay_b_thr_o),
      .relay_o(relay_b_o)
   );
   assign unit_o = unit_q;
   assign screen_o = scr_q;
   assign zero_point_o = zero_q;
   assign span_value_o = span_q;
   assign lin_min_o = lin_min_q;
   assign lin_max_o = lin_max_q;

   a_store_main: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
      keys_i.store |=> scr_q == SRS_SCR_MAIN) else $error("store did not return");
   a_zero_capture: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
      keys_i.zero_calibration && scr_q == SRS_SCR_ZERO |=> zero_q == $past(sensor_raw_i))
      else $error("zero point not captured");
   a_span_commit: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
      scr_q == SRS_SCR_SPAN && keys_i.store |=> span_q == $past(span_edit_q))
      else $error("span not committed");
   a_addr_join: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
      ##1 addr_up && !sel_hi_q |=> station_addr_o[3:0] == $past(stn_lo_q) + 4'h1)
      else $error("address low nibble wrong");
   a_unit_restore: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
      restore |=> lin_min_q == `SRS_LIN_MIN_RST && lin_max_q == `SRS_LIN_MAX_RST)
      else $error("linear limits not restored");
   a_disable_pin: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
      !relay_disable_n_i [*4] |-> !relay_a_o && !relay_b_o)
      else $error("relay driven while pin low");
   c_unit_change: cover property (@(posedge core_clk_i) disable iff (!resetn_i) restore);
   c_zero_cal: cover property (@(posedge core_clk_i) disable iff (!resetn_i)
      keys_i.zero_calibration && scr_q == SRS_SCR_ZERO);
   c_addr_screen: cover property (@(posedge core_clk_i) disable iff (!resetn_i)
      scr_q == SRS_SCR_ADDR);
endmodule

// File: srs_panel.sv
`timescale 1ns/100ps
// front panel keys and relay disable strap, as the operator drives them
module srs_panel (
   // clock
   input wire logic core_clk_i,
   // keys and disable pin
   output srs_pkg::srs_keys_t keys_o,
   output logic relay_disable_n_o
);
   import srs_pkg::*;
   // ------------------------------
   // idle panel: no key, pin open
   // ------------------------------
   initial begin
      keys_o = '0;
      relay_disable_n_o = 1'b1;
   end
   // one key a pulse, then a quiet cycle so two presses never merge
   task automatic press(input srs_keys_t k);
      @(posedge core_clk_i);
      keys_o <= k;
      @(posedge core_clk_i);
      keys_o <= '0;
      #1;
   endtask
   // strap the disable pin; low ties it to ground
   task automatic strap(input logic v);
      @(posedge core_clk_i);
      relay_disable_n_o <= v;
   endtask
endmodule

// File: tb_srs_top.sv
`timescale 1ns/100ps
module tb_srs_top;
   import srs_pkg::*;
   logic core_clk_i, resetn_i, dis_n, relay_a, relay_b, addr_match;
   logic [23:0] pressure_i, sensor_raw_i, zero_pt, span, lin_min, lin_max;
   logic [7:0] cmd_addr_i, stn;
   srs_keys_t keys;
   srs_thr_t thr_a, thr_b;
   srs_unit_t unit;
   srs_screen_t screen;
   int fail_count, n_tests;
   localparam srs_keys_t K_STORE = 6'h20, K_NEXT = 6'h10, K_UP = 6'h08;
   localparam srs_keys_t K_DOWN = 6'h04, K_ZERO = 6'h02;
   localparam logic [47:0] THR_RST = 48'h0003E8_0007D0;
   srs_top u_srs_top (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .pressure_i(pressure_i),
      .sensor_raw_i(sensor_raw_i), .relay_disable_n_i(dis_n), .keys_i(keys),
      .cmd_addr_i(cmd_addr_i), .relay_a_o(relay_a), .relay_b_o(relay_b),
      .relay_a_thr_o(thr_a), .relay_b_thr_o(thr_b), .station_addr_o(stn),
      .addr_match_o(addr_match), .unit_o(unit), .screen_o(screen), .zero_point_o(zero_pt),
      .span_value_o(span), .lin_min_o(lin_min), .lin_max_o(lin_max));
   srs_panel u_srs_panel (.core_clk_i(core_clk_i), .keys_o(keys), .relay_disable_n_o(dis_n));
   // ------------------------------
   // helpers
   // ------------------------------
   task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
      n_tests++;
      if (seen !== exp) begin
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
         fail_count++;
      end
   endtask
   task automatic settle();
      @(posedge core_clk_i);
      #1;
   endtask
   task automatic keys_n(input srs_keys_t k, input int n);
      repeat (n) u_srs_panel.press(k);
      settle();
   endtask
   // pressure moves on the edge, then the relays get three cycles to follow
   task automatic set_p(input logic [23:0] v);
      @(posedge core_clk_i);
      pressure_i <= v;
      repeat (3) settle();
   endtask
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // ------------------------------
   // scenarios
   // ------------------------------
   task automatic t_reset();
      chk(thr_a, THR_RST);
      chk(thr_b, THR_RST);
      chk(stn, 8'h01);
      chk(unit, SRS_TORR);
      chk(span, 24'h73F780);
      chk({lin_min, lin_max}, 48'h00000A_002710);
      chk(zero_pt, 24'h000000);
      chk(screen, SRS_SCR_MAIN);
      $display("test reset done");
   endtask
   // both edges of the band, each touched exactly at its value
   task automatic t_hyst();
      set_p(24'h0003E7);
      chk({relay_a, relay_b}, 2'h3);
      set_p(24'h0007D0);
      chk({relay_a, relay_b}, 2'h3);
      set_p(24'h0007D1);
      chk({relay_a, relay_b}, 2'h0);
      set_p(24'h0003E8);
      chk({relay_a, relay_b}, 2'h0);
      $display("test hysteresis done");
   endtask
   task automatic t_disable();
      set_p(24'h000001);
      u_srs_panel.strap(1'b0);
      for (int i = 0; i < 3; i++) begin
         settle();
         if (relay_a === 1'b0 && relay_b === 1'b0) break;
      end
      chk({relay_a, relay_b}, 2'h0);
      repeat (6) settle();
      chk({relay_a, relay_b}, 2'h0);
      u_srs_panel.strap(1'b1);
      repeat (4) settle();
      chk({relay_a, relay_b}, 2'h3);
      $display("test disable done");
   endtask
   task automatic t_span();
      set_p(24'h100000);
      keys_n(K_NEXT, 3);
      chk(screen, SRS_SCR_SPAN);
      keys_n(K_UP, 3);
      keys_n(K_DOWN, 1);
      keys_n(K_STORE, 1);
      chk(span, 24'h100002);
      chk(screen, SRS_SCR_MAIN);
      $display("test span done");
   endtask
   // gauge pumped to the zero limit, 1 count, before the capture
   task automatic t_zero();
      set_p(24'h000001);
      @(posedge core_clk_i);
      sensor_raw_i <= 24'h123456;
      keys_n(K_NEXT, 1);
      chk(screen, SRS_SCR_ZERO);
      keys_n(K_ZERO, 1);
      chk(zero_pt, 24'h123456);
      keys_n(K_STORE, 1);
      chk(screen, SRS_SCR_MAIN);
      $display("test zero done");
   endtask
   // push each of relay a's thresholds into the other one, then change units
   task automatic t_edit();
      keys_n(K_NEXT, 4);
      chk(screen, SRS_SCR_SETPT);
      keys_n(K_NEXT, 1);
      keys_n(K_DOWN, 1100);
      chk(thr_a, 48'h0003E8_0003E9);
      keys_n(K_STORE, 1);
      keys_n(K_NEXT, 4);
      keys_n(K_UP, 3);
      chk(thr_a, 48'h0003E8_0003E9);
      chk(thr_b, THR_RST);
      keys_n(K_STORE, 1);
      keys_n(K_NEXT, 2);
      chk(screen, SRS_SCR_UNIT);
      keys_n(K_UP, 1);
      chk(unit, SRS_MBAR);
      chk(thr_a, THR_RST);
      chk({lin_min, lin_max}, 48'h00000A_002710);
      keys_n(K_UP, 1);
      chk(unit, SRS_PA);
      keys_n(K_UP, 1);
      chk(unit, SRS_TORR);
      keys_n(K_DOWN, 1);
      chk(unit, SRS_PA);
      keys_n(K_UP, 1);
      chk(unit, SRS_TORR);
      keys_n(K_STORE, 1);
      $display("test edit done");
   endtask
   task automatic t_addr();
      keys_n(K_NEXT, 8);
      chk(screen, SRS_SCR_ADDR);
      keys_n(K_UP, 4);
      chk(stn, 8'h05);
      keys_n(K_NEXT, 1);
      keys_n(K_UP, 15);
      chk(stn, 8'hF5);
      @(posedge core_clk_i);
      cmd_addr_i <= 8'hF5;
      settle();
      chk(addr_match, 1'b1);
      @(posedge core_clk_i);
      cmd_addr_i <= 8'h05;
      settle();
      chk(addr_match, 1'b0);
      keys_n(K_STORE, 1);
      $display("test address done");
   endtask
   // ------------------------------
   // clock, reset, sequence
   // ------------------------------
   initial begin
      core_clk_i = 1'b0;
      forever #10 core_clk_i = ~core_clk_i;
   end
   // a hang past this bound counts as a mismatch
   initial begin
      repeat (60000) @(posedge core_clk_i);
      fail_count++;
      close_out();
   end
   initial begin
      fail_count = 0;
      n_tests = 0;
      resetn_i = 1'b0;
      pressure_i = 24'h000500;
      sensor_raw_i = 24'h000000;
      cmd_addr_i = 8'h00;
      repeat (12) @(posedge core_clk_i);
      resetn_i <= 1'b1;
      settle();
      t_reset();
      t_hyst();
      t_disable();
      t_span();
      t_zero();
      t_edit();
      t_addr();
      close_out();
   end
endmodule
